// [inc/pwos_consts.svh]
`ifndef PWOS_CONSTS_SVH
`define PWOS_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PWOS_OFS_HI_THR_L    8'h46
`define PWOS_OFS_HI_THR_H    8'h47
`define PWOS_OFS_LO_THR_L    8'h48
`define PWOS_OFS_LO_THR_H    8'h49
`define PWOS_OFS_TRIM_L      8'h4C
`define PWOS_OFS_TRIM_H      8'h4D
`define PWOS_OFS_STATUS      8'h60

// ----------------------------------------------------------------
// Status field positions and reset values
// ----------------------------------------------------------------
`define PWOS_ST_FAILED_BIT   0
`define PWOS_CM_FAULT_BIT    1
`define PWOS_ST_RUNNING_BIT  2
`define PWOS_ST_NEVER_BIT    3
`define PWOS_THR_RESET       16'h0000
`define PWOS_TRIM_RESET      16'h0000
`define PWOS_STATUS_RESET    8'h08

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PWOS_DSP_INIT_CYCLES 16'h0040

`endif

// [inc/pwos_pkg.sv]
`default_nettype none
package pwos_pkg;
    typedef enum logic [1:0] {PWOS_STRETCH_OFF, PWOS_STRETCH_16, PWOS_STRETCH_64, PWOS_STRETCH_256} pwos_stretch_t;
    typedef enum {PWOS_DSP_RUN, PWOS_DSP_INIT} pwos_dsp_state_t;
endpackage : pwos_pkg
`default_nettype wire

// [rtl/pwos_thr_cmp.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pwos_consts.svh"

module pwos_thr_cmp
#(
    parameter int WIDTH = 16
)
(
    // Threshold and sample
    input  wire logic [WIDTH-1:0] threshold,
    input  wire logic [WIDTH-1:0] sample,
    input  wire logic             is_high,
    // Result
    output logic                  enabled,
    output logic                  beyond
);
    // A zero threshold drops out of the comparison
    assign enabled = (threshold != '0);
    assign beyond  = enabled && (is_high ? (sample > threshold) : (sample < threshold));
endmodule : pwos_thr_cmp

`default_nettype wire

// [rtl/pwos_regs.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pwos_consts.svh"

module pwos_regs
    import pwos_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Configuration from elsewhere
    input  wire logic        init_done_lock,
    input  wire logic        window_inside,
    input  wire logic [1:0]  irq_stretch_select,
    input  wire logic [3:0]  selftest_select,
    // Signal path events
    input  wire logic        sample_valid,
    input  wire logic [15:0] raw_pressure,
    input  wire logic        cm_out_of_limits,
    input  wire logic        selftest_fail,
    input  wire logic        cm_fault_sent,
    // Results
    output logic [15:0]      sensor_result,
    output logic             result_valid,
    output logic             dsp_restart,
    output logic             irq_out,
    output logic             reg_parity_error
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [15:0]     hi_thr_q, hi_thr_d;
    logic [15:0]     lo_thr_q, lo_thr_d;
    logic [15:0]     trim_q, trim_d;
    logic [47:0]     par_src;
    logic            par_q, par_d;
    logic            never_q, never_d;
    logic            cm_q, cm_d;
    logic            fail_q, fail_d;
    logic [7:0]      rdata_q, rdata_d;
    logic            perr_q, perr_d;
    logic            wr_ok;
    logic            trim_wr;

    assign wr_ok   = reg_wr && !init_done_lock;
    assign trim_wr = wr_ok && (reg_addr == `PWOS_OFS_TRIM_L || reg_addr == `PWOS_OFS_TRIM_H);
    assign par_src = {hi_thr_q, lo_thr_q, trim_q};

    always_comb
    begin
        hi_thr_d = hi_thr_q;
        lo_thr_d = lo_thr_q;
        trim_d   = trim_q;
        if (wr_ok)
        begin
            case (reg_addr)
                `PWOS_OFS_HI_THR_L: hi_thr_d[7:0]  = reg_wdata;
                `PWOS_OFS_HI_THR_H: hi_thr_d[15:8] = reg_wdata;
                `PWOS_OFS_LO_THR_L: lo_thr_d[7:0]  = reg_wdata;
                `PWOS_OFS_LO_THR_H: lo_thr_d[15:8] = reg_wdata;
                `PWOS_OFS_TRIM_L:   trim_d[7:0]    = reg_wdata;
                `PWOS_OFS_TRIM_H:   trim_d[15:8]   = reg_wdata;
                default:            trim_d         = trim_q;
            endcase
        end
        // Parity tracks legal writes; a flip outside a write shows as mismatch
        par_d  = ^{hi_thr_d, lo_thr_d, trim_d};
        perr_d = perr_q || (par_q != ^par_src);
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    logic st_read;
    assign st_read = reg_rd && (reg_addr == `PWOS_OFS_STATUS);

    always_comb
    begin
        never_d = never_q && (selftest_select == 4'h0);
        // Set wins over a clear in the same cycle
        cm_d    = cm_out_of_limits || (cm_q && !st_read && !cm_fault_sent);
        fail_d  = fail_q || selftest_fail;
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `PWOS_OFS_HI_THR_L: rdata_d = hi_thr_q[7:0];
                `PWOS_OFS_HI_THR_H: rdata_d = hi_thr_q[15:8];
                `PWOS_OFS_LO_THR_L: rdata_d = lo_thr_q[7:0];
                `PWOS_OFS_LO_THR_H: rdata_d = lo_thr_q[15:8];
                `PWOS_OFS_TRIM_L:   rdata_d = trim_q[7:0];
                `PWOS_OFS_TRIM_H:   rdata_d = trim_q[15:8];
                `PWOS_OFS_STATUS:
                begin
                    rdata_d[`PWOS_ST_NEVER_BIT]   = never_q;
                    rdata_d[`PWOS_ST_RUNNING_BIT] = |selftest_select;
                    rdata_d[`PWOS_CM_FAULT_BIT]   = cm_q;
                    rdata_d[`PWOS_ST_FAILED_BIT]  = fail_q;
                end
                default:            rdata_d = 8'h00;
            endcase
        end
        else
        begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            hi_thr_q <= `PWOS_THR_RESET;
            lo_thr_q <= `PWOS_THR_RESET;
            trim_q   <= `PWOS_TRIM_RESET;
            par_q    <= 1'b0;
            perr_q   <= 1'b0;
            never_q  <= 1'(`PWOS_STATUS_RESET >> `PWOS_ST_NEVER_BIT);
            cm_q     <= 1'b0;
            fail_q   <= 1'b0;
            rdata_q  <= 8'h00;
        end
        else
        begin
            hi_thr_q <= hi_thr_d;
            lo_thr_q <= lo_thr_d;
            trim_q   <= trim_d;
            par_q    <= par_d;
            perr_q   <= perr_d;
            never_q  <= never_d;
            cm_q     <= cm_d;
            fail_q   <= fail_d;
            rdata_q  <= rdata_d;
        end
    end

    assign reg_rdata        = rdata_q;
    assign reg_parity_error = perr_q;

    // ------------------------------------------------------------
    // Signal path restart
    // ------------------------------------------------------------
    pwos_dsp_state_t dsp_q, dsp_d;
    logic [15:0]     init_cnt_q, init_cnt_d;
    logic            restart_q, restart_d;

    always_comb
    begin
        dsp_d      = dsp_q;
        init_cnt_d = init_cnt_q;
        restart_d  = 1'b0;
        case (dsp_q)
            PWOS_DSP_RUN:
                if (trim_wr && trim_d != trim_q)
                begin
                    dsp_d      = PWOS_DSP_INIT;
                    init_cnt_d = `PWOS_DSP_INIT_CYCLES;
                    restart_d  = 1'b1;
                end
            PWOS_DSP_INIT:
                if (trim_wr && trim_d != trim_q)
                begin
                    init_cnt_d = `PWOS_DSP_INIT_CYCLES;
                    restart_d  = 1'b1;
                end
                else if (init_cnt_q == 16'h0001)
                begin
                    dsp_d      = PWOS_DSP_RUN;
                    init_cnt_d = 16'h0000;
                end
                else
                begin
                    init_cnt_d = init_cnt_q - 16'h0001;
                end
            default:
                dsp_d = PWOS_DSP_RUN;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            dsp_q      <= PWOS_DSP_RUN;
            init_cnt_q <= 16'h0000;
            restart_q  <= 1'b0;
        end
        else
        begin
            dsp_q      <= dsp_d;
            init_cnt_q <= init_cnt_d;
            restart_q  <= restart_d;
        end
    end

    assign dsp_restart = restart_q;

    // ------------------------------------------------------------
    // Result and window comparator
    // ------------------------------------------------------------
    logic [15:0] adj;
    logic        hi_en, hi_beyond, lo_en, lo_beyond, outside, cond;
    logic [15:0] result_q, result_d;
    logic        valid_q, valid_d;
    logic        irq_q, irq_d;

    // Wraps modulo 2^16; the user must keep the trim from railing the output
    assign adj = raw_pressure + trim_q;

    pwos_thr_cmp #(.WIDTH(16)) u_hi
    (
        .threshold (hi_thr_q),
        .sample    (adj),
        .is_high   (1'b1),
        .enabled   (hi_en),
        .beyond    (hi_beyond)
    );

    pwos_thr_cmp #(.WIDTH(16)) u_lo
    (
        .threshold (lo_thr_q),
        .sample    (adj),
        .is_high   (1'b0),
        .enabled   (lo_en),
        .beyond    (lo_beyond)
    );

    assign outside = hi_beyond || lo_beyond;
    assign cond    = (hi_en || lo_en) && (window_inside ? !outside : outside);

    always_comb
    begin
        result_d = result_q;
        valid_d  = valid_q && (dsp_d == PWOS_DSP_RUN);
        irq_d    = irq_q;
        if (sample_valid && dsp_q == PWOS_DSP_RUN && dsp_d == PWOS_DSP_RUN)
        begin
            result_d = adj;
            valid_d  = 1'b1;
            // Stretch timer lives elsewhere; non-zero selection holds last level
            if (irq_stretch_select == PWOS_STRETCH_OFF)
            begin
                irq_d = cond;
            end
        end
        if (!hi_en && !lo_en)
        begin
            irq_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            result_q <= 16'h0000;
            valid_q  <= 1'b0;
            irq_q    <= 1'b0;
        end
        else
        begin
            result_q <= result_d;
            valid_q  <= valid_d;
            irq_q    <= irq_d;
        end
    end

    assign sensor_result = result_q;
    assign result_valid  = valid_q;
    assign irq_out       = irq_q;
endmodule : pwos_regs

`default_nettype wire

// [test/pwos_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module pwos_monitor (
    // Watched ports
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       init_done_lock,
    input wire logic [3:0] selftest_select,
    input wire logic       selftest_fail,
    input wire logic       cm_out_of_limits,
    input wire logic       cm_fault_sent,
    input wire logic       result_valid,
    input wire logic       dsp_restart,
    input wire logic       reg_parity_error
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic st_rd;
    assign st_rd = reg_rd && reg_addr == 8'h60;
    AST_LOCK: assert property (reg_wr && init_done_lock && reg_addr[7:1] == 7'h26 |=> !dsp_restart)
        else $error("locked trim write restarted");
    AST_PARITY: assert property (!reg_parity_error) else $error("false parity error");
    AST_RST_INV: assert property (dsp_restart |-> !result_valid) else $error("valid during restart");
    AST_INIT: assert property (dsp_restart |=> !result_valid [*8]) else $error("init too short");
    AST_NEVER: assert property (st_rd && !$past(reset) && |selftest_select && $past(selftest_select) != 4'h0 |=> !reg_rdata[3])
        else $error("never-run bit not cleared");
    AST_RUN: assert property (st_rd |=> reg_rdata[2] == (|$past(selftest_select)))
        else $error("running bit wrong");
    // Status read or fault send in between would clear it legally
    AST_CM_SET: assert property (cm_out_of_limits ##1 !cm_fault_sent && !st_rd ##1 st_rd |=> reg_rdata[1])
        else $error("cm fault not set");
    AST_CM_CLR: assert property (st_rd && !cm_out_of_limits ##1 !cm_out_of_limits ##1 st_rd |=> !reg_rdata[1])
        else $error("cm fault not cleared");
    AST_FAIL: assert property (selftest_fail ##2 st_rd |=> reg_rdata[0]) else $error("fail bit lost");
endmodule : pwos_monitor
bind pwos_regs pwos_monitor i_pwos_monitor
(
    .sys_clk          (sys_clk),
    .reset            (reset),
    .reg_addr         (reg_addr),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .init_done_lock   (init_done_lock),
    .selftest_select  (selftest_select),
    .selftest_fail    (selftest_fail),
    .cm_out_of_limits (cm_out_of_limits),
    .cm_fault_sent    (cm_fault_sent),
    .result_valid     (result_valid),
    .dsp_restart      (dsp_restart),
    .reg_parity_error (reg_parity_error)
);
`default_nettype wire

// [test/pwos_host.sv]
`timescale 1ns/100ps
`default_nettype none
module pwos_host (
    // Register port
    input  wire logic       sys_clk,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // Idle lines flip so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        v = reg_rdata;
    endtask : rd
endmodule : pwos_host
`default_nettype wire

// [test/pressure_window_offset_status_test.sv]
`timescale 1ns/100ps
`default_nettype none
module pressure_window_offset_status_test;
    logic sys_clk, reset, init_done_lock, window_inside, sample_valid, reg_wr, reg_rd;
    logic result_valid, dsp_restart, irq_out, reg_parity_error, cm_out_of_limits, selftest_fail, cm_fault_sent;
    logic [1:0] irq_stretch_select;
    logic [2:0] ev;
    logic [3:0] selftest_select;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [15:0] raw_pressure, sensor_result;
    logic [31:0] seed;
    int n_mismatch, check_count, cyc, n_restart, hi, lo, trim, s, b, q;
    assign {cm_fault_sent, cm_out_of_limits, selftest_fail} = ev;
    pwos_regs i_pwos_regs
    (
        .sys_clk            (sys_clk),
        .reset              (reset),
        .reg_addr           (reg_addr),
        .reg_wr             (reg_wr),
        .reg_wdata          (reg_wdata),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .init_done_lock     (init_done_lock),
        .window_inside      (window_inside),
        .irq_stretch_select (irq_stretch_select),
        .selftest_select    (selftest_select),
        .sample_valid       (sample_valid),
        .raw_pressure       (raw_pressure),
        .cm_out_of_limits   (cm_out_of_limits),
        .selftest_fail      (selftest_fail),
        .cm_fault_sent      (cm_fault_sent),
        .sensor_result      (sensor_result),
        .result_valid       (result_valid),
        .dsp_restart        (dsp_restart),
        .irq_out            (irq_out),
        .reg_parity_error   (reg_parity_error)
    );
    pwos_host i_pwos_host
    (
        .sys_clk   (sys_clk),
        .reg_addr  (reg_addr),
        .reg_wr    (reg_wr),
        .reg_wdata (reg_wdata),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata)
    );
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        n_restart += (dsp_restart === 1'b1);
        if (cyc == 5000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h, expected %h", $time, seen, want);
        end
    endtask : check
    task automatic end_of_test();
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic do_reset();
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
    endtask : do_reset
    task automatic set16(input logic [7:0] a, input logic [15:0] v);
        i_pwos_host.wr(a, v[7:0]);
        i_pwos_host.wr(a + 8'h01, v[15:8]);
    endtask : set16
    task automatic pulse(input logic [2:0] v);
        @(posedge sys_clk);
        ev <= v;
        @(posedge sys_clk);
        ev <= 3'h0;
    endtask : pulse
    task automatic status(input logic [7:0] want);
        i_pwos_host.rd(8'h60, d);
        check(d, want);
    endtask : status
    task automatic sample(input logic [15:0] raw);
        @(posedge sys_clk);
        raw_pressure <= raw;
        sample_valid <= 1'b1;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        raw_pressure <= ~raw;
        #1;
        s = (raw + trim) & 'hFFFF;
        b = (hi != 0 && s > hi) || (lo != 0 && s < lo);
        check(sensor_result, s);
        // Non-zero stretch holds the pin; both thresholds zero still forces it off
        if (irq_stretch_select == 2'h0 || (hi == 0 && lo == 0))
            q = (hi || lo) && (b != window_inside);
        check(irq_out, q);
        check(result_valid, 1);
    endtask : sample
    initial
    begin
        sys_clk = 1'b0;
        reset = 1'b1;
        {init_done_lock, window_inside, sample_valid, ev} = 6'h10;
        raw_pressure = 16'h0000;
        irq_stretch_select = 2'h0;
        selftest_select = 4'h0;
        seed = 32'hD784;
        do_reset();
        for (int a = 'h46; a < 'h4E; a++)
        begin
            i_pwos_host.rd(a[7:0], d);
            check(d, 16'h0000);
        end
        status(8'h08);
        sample(xs());
        trim = (xs() | 'h0101) & 'hFFFF;
        set16(8'h4C, trim);
        repeat (3) @(posedge sys_clk);
        check(result_valid, 0);
        check(n_restart, 2);
        repeat (70) @(posedge sys_clk);
        for (int k = 0; k < 40; k++)
        begin
            hi = xs() % 3 ? xs() & 'hFFFF : 0;
            lo = xs() % 3 ? xs() & 'hFFFF : 0;
            @(posedge sys_clk);
            window_inside <= (xs() % 2) != 0;
            set16(8'h46, hi);
            set16(8'h48, lo);
            i_pwos_host.rd(8'h47, d);
            check(d, hi >> 8);
            sample(k % 3 == 0 ? hi - trim : k % 3 == 1 ? lo - trim - 1 : xs());
        end
        @(posedge sys_clk);
        init_done_lock <= 1'b1;
        irq_stretch_select <= 2'h2;
        i_pwos_host.wr(8'h46, ~hi[7:0]);
        i_pwos_host.wr(8'h4D, ~trim[15:8]);
        i_pwos_host.rd(8'h46, d);
        check(d, hi & 'hFF);
        i_pwos_host.rd(8'h4D, d);
        check(d, trim >> 8);
        check(n_restart, 2);
        sample(xs());
        @(posedge sys_clk);
        selftest_select <= 4'(xs() % 15 + 1);
        status(8'h04);
        @(posedge sys_clk);
        selftest_select <= 4'h0;
        pulse(3'h2);
        status(8'h02);
        status(8'h00);
        pulse(3'h2);
        pulse(3'h4);
        status(8'h00);
        pulse(3'h1);
        status(8'h01);
        i_pwos_host.wr(8'h60, 8'hFF);
        status(8'h01);
        check(reg_parity_error, 0);
        do_reset();
        status(8'h08);
        end_of_test();
    end
endmodule : pressure_window_offset_status_test
`default_nettype wire
